// file: include/asp_pkg.sv
// shared constants, register map and carrier types of the serial port
// assumes a 32-bit classic wishbone slave, word aligned registers
package asp_pkg;

    // ------------------------------------------------------------------
    // register word indexes (byte address = index * 4)
    // ------------------------------------------------------------------
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_DIV  = 3'h1;
    localparam logic [2:0] REG_TXD  = 3'h2;
    localparam logic [2:0] REG_RXD  = 3'h3;
    localparam logic [2:0] REG_STAT = 3'h4;
    localparam logic [2:0] REG_ISR  = 3'h5;
    localparam logic [2:0] REG_IMR  = 3'h6;

    // ------------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------------
    localparam logic [15:0] CTRL_RST = 16'h0003;
    localparam logic [15:0] DIV_RST  = 16'h0001;
    localparam int          PRE_DIV  = 32;
    localparam logic [4:0]  PRE_MAX  = 5'(PRE_DIV - 1);
    localparam logic [3:0]  SUB_MAX  = 4'hf;
    localparam logic [3:0]  SUB_HALF = 4'h7;
    localparam logic [2:0]  LEN_BASE = 3'h4;
    localparam logic [2:0]  SYNC_RST = 3'h3;

    // ------------------------------------------------------------------
    // modes, field and event positions
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_NORM  = 2'h0;
    localparam logic [1:0] MODE_ECHO  = 2'h1;
    localparam logic [1:0] MODE_LLOOP = 2'h2;
    localparam logic [1:0] MODE_RLOOP = 2'h3;
    localparam int TXD_ADDR  = 8;
    localparam int ST_TXEMP  = 0;
    localparam int ST_TXDONE = 1;
    localparam int ST_RXRDY  = 2;
    localparam int ST_RXFULL = 3;
    localparam int EV_RXRDY  = 0;
    localparam int EV_TXEMP  = 1;
    localparam int EV_OVR    = 2;
    localparam int EV_FRM    = 3;
    localparam int EV_PAR    = 4;
    localparam int EV_BRK    = 5;
    localparam int EV_W      = 6;
    localparam int FIFO_DEPTH = 3;
    localparam logic [1:0] RTS_LIMIT = 2'h2;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       rx_en;
        logic       tx_en;
        logic       dma_rx_ne;
        logic       clk_ext;
        logic       multidrop;
        logic [1:0] mode;
        logic       flow_en;
        logic       brk;
        logic       stop2;
        logic       par_lvl;
        logic       par_force;
        logic       par_odd;
        logic       par_en;
        logic [1:0] len;
    } asp_ctrl_t;

    typedef struct packed {
        logic       brk;
        logic       ferr;
        logic       perr;
        logic       addr;
        logic [7:0] data;
    } asp_rxchar_t;

endpackage

// file: rtl/asp_rx_fifo.sv
// three-entry holding store for received characters
// ignores a pop when empty and a push when full
`timescale 1ns/1ps
module asp_rx_fifo
    import asp_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        push_i,
    input  asp_rxchar_t      push_data_i,
    input  wire logic        pop_i,
    output asp_rxchar_t      rd_data_o,
    output logic [1:0]       count_o
);
    asp_rxchar_t mem_q [FIFO_DEPTH];
    logic [1:0]  wp_q;
    logic [1:0]  rp_q;
    logic [1:0]  cnt_q;
    wire         full  = (cnt_q == 2'(FIFO_DEPTH));
    wire         empty = (cnt_q == 2'h0);
    wire         push_ok = push_i & ~full;
    wire         pop_ok  = pop_i & ~empty;

    // pointer wrap at the odd depth
    function automatic logic [1:0] inc(input logic [1:0] p);
        inc = (p == 2'(FIFO_DEPTH - 1)) ? 2'h0 : p + 2'h1;
    endfunction

    // storage carries no reset; pointers, count and head take one
    always_ff @(posedge clk_i) begin
        if (push_ok) begin
            mem_q[wp_q] <= push_data_i;
        end
    end

    // pointers, fill level, registered head
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_q      <= 2'h0;
            rp_q      <= 2'h0;
            cnt_q     <= 2'h0;
            rd_data_o <= '0;
        end else begin
            if (push_ok) wp_q <= inc(wp_q);
            if (pop_ok) rp_q <= inc(rp_q);
            cnt_q     <= cnt_q + {1'b0, push_ok} - {1'b0, pop_ok};
            rd_data_o <= mem_q[rp_q];
        end
    end

    assign count_o = cnt_q;
endmodule

// file: rtl/asp_top.sv
// asynchronous serial port with flow control, wishbone register slave
// assumes one clock, synchronous reset, pins asynchronous to clk_i
`timescale 1ns/1ps
module asp_top
    import asp_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        serial_rx_i,
    output logic             serial_tx_o,
    input  wire logic        clear_to_send_in_n_i,
    output logic             request_to_send_out_n_o,
    input  wire logic        external_timer_clock_input_i,
    output logic             irq_o,
    output logic             dma_rx_req_o,
    output logic             dma_tx_req_o
);
    typedef enum logic [4:0] {
        TX_IDLE  = 5'h01,
        TX_START = 5'h02,
        TX_DATA  = 5'h04,
        TX_PAR   = 5'h08,
        TX_STOP  = 5'h10
    } asp_tx_st_t;

    typedef enum logic [5:0] {
        RX_IDLE  = 6'h01,
        RX_START = 6'h02,
        RX_DATA  = 6'h04,
        RX_PAR   = 6'h08,
        RX_STOP  = 6'h10,
        RX_BRKW  = 6'h20
    } asp_rx_st_t;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // keep only the bits of the programmed character length
    function automatic logic [7:0] mask_len(input logic [7:0] d,
                                            input logic [1:0] len);
        mask_len = d & (8'hff >> (2'h3 - len));
    endfunction

    // parity slot value, shared by transmitter and receiver check
    function automatic logic par_calc(input logic [7:0] d,
                                      input asp_ctrl_t c);
        par_calc = c.par_force ? c.par_lvl
                               : (^mask_len(d, c.len)) ^ c.par_odd;
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers: {timer clock, cts_n, rxd}
    // ------------------------------------------------------------------
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic       ext_prev_q;
    // first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_q   <= SYNC_RST;
            pin_s2_q   <= SYNC_RST;
            ext_prev_q <= 1'b0;
        end else begin
            pin_s1_q   <= {external_timer_clock_input_i,
                           clear_to_send_in_n_i, serial_rx_i};
            pin_s2_q   <= pin_s1_q;
            ext_prev_q <= pin_s2_q[2];
        end
    end
    wire rxd_s   = pin_s2_q[0];
    wire cts_n_s = pin_s2_q[1];
    wire ext_rise = pin_s2_q[2] & ~ext_prev_q;

    // ------------------------------------------------------------------
    // registers and bus decode
    // ------------------------------------------------------------------
    asp_ctrl_t      ctrl_q;
    logic [15:0]    div_q;
    logic [8:0]     hold_q;
    logic           hold_v_q;
    logic [EV_W-1:0] ist_q;
    logic [EV_W-1:0] imr_q;
    logic [31:0]    rd_mux;
    asp_rxchar_t    fifo_head;
    logic [1:0]     fifo_cnt;

    wire        acc   = cyc_i & stb_i & ~ack_o;
    wire        wr    = acc & we_i;
    wire        rd    = acc & ~we_i;
    wire [2:0]  idx   = adr_i[4:2];
    wire [31:0] ctrl_m = merge({16'h0, ctrl_q}, dat_i, sel_i);
    wire [31:0] div_m  = merge({16'h0, div_q}, dat_i, sel_i);
    wire [31:0] imr_m  = merge({26'h0, imr_q}, dat_i, sel_i);
    wire [31:0] clr_m  = merge(32'h0, dat_i, sel_i);
    wire [31:0] txd_m  = merge(32'h0, dat_i, sel_i);
    // a write while the holding word is full is dropped
    wire        txd_wr = wr & (idx == REG_TXD) & ~hold_v_q;
    wire        rx_pop = rd & (idx == REG_RXD);
    wire        rx_empty = (fifo_cnt == 2'h0);
    wire        rx_full  = (fifo_cnt == 2'(FIFO_DEPTH));

    // ------------------------------------------------------------------
    // baud generation
    // ------------------------------------------------------------------
    logic [4:0]  pre_q;
    logic [15:0] dcnt_q;
    wire         ref_tick = ctrl_q.clk_ext ? ext_rise
                                           : (pre_q == PRE_MAX);
    // divisor zero behaves as one
    wire [15:0]  div_m1  = (div_q == 16'h0) ? 16'h0 : div_q - 16'h1;
    wire         smp_tick = ref_tick & (dcnt_q >= div_m1);
    // only ext edges advance the divider in external mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_q  <= 5'h0;
            dcnt_q <= 16'h0;
        end else begin
            pre_q  <= pre_q + 5'h1;
            if (ref_tick) dcnt_q <= smp_tick ? 16'h0 : dcnt_q + 16'h1;
        end
    end

    // ------------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------------
    asp_tx_st_t tx_st_q, tx_st_d;
    logic [7:0] tx_sr_q, tx_sr_d;
    logic [2:0] tx_cnt_q, tx_cnt_d;
    logic [3:0] tx_sub_q, tx_sub_d;
    logic       tx_stop_q, tx_stop_d;
    logic       tx_par_q;
    logic       tx_load;
    wire        par_on  = ctrl_q.par_en | ctrl_q.multidrop;
    wire [2:0]  last_bit = LEN_BASE + {1'b0, ctrl_q.len};
    wire        cts_ok  = ~ctrl_q.flow_en | ~cts_n_s;
    wire        tx_go   = hold_v_q & ctrl_q.tx_en & cts_ok & ~ctrl_q.brk;
    wire        tx_end  = smp_tick & (tx_sub_q == SUB_MAX);
    // multidrop takes over the parity slot
    wire        tx_par_new = ctrl_q.multidrop ? hold_q[TXD_ADDR]
                                              : par_calc(hold_q[7:0], ctrl_q);
    wire        tx_line = (tx_st_q == TX_START) ? 1'b0 :
                          (tx_st_q == TX_DATA)  ? tx_sr_q[0] :
                          (tx_st_q == TX_PAR)   ? tx_par_q : 1'b1;

    // one character frame from holding word to line
    always_comb begin
        tx_st_d   = tx_st_q;
        tx_sr_d   = tx_sr_q;
        tx_cnt_d  = tx_cnt_q;
        tx_stop_d = tx_stop_q;
        tx_load   = 1'b0;
        tx_sub_d  = (smp_tick && tx_st_q != TX_IDLE) ? tx_sub_q + 4'h1
                                                     : tx_sub_q;
        case (tx_st_q)
            TX_IDLE: if (tx_go) begin
                tx_load  = 1'b1;
                tx_sr_d  = hold_q[7:0];
                tx_sub_d = 4'h0;
                tx_st_d  = TX_START;
            end
            TX_START: if (tx_end) begin
                tx_cnt_d = 3'h0;
                tx_st_d  = TX_DATA;
            end
            TX_DATA: if (tx_end) begin
                tx_sr_d   = {1'b0, tx_sr_q[7:1]};
                tx_cnt_d  = tx_cnt_q + 3'h1;
                tx_stop_d = 1'b0;
                if (tx_cnt_q == last_bit) begin
                    tx_st_d = par_on ? TX_PAR : TX_STOP;
                end
            end
            TX_PAR: if (tx_end) begin
                tx_st_d = TX_STOP;
            end
            TX_STOP: if (tx_end) begin
                if (ctrl_q.stop2 && !tx_stop_q) begin
                    tx_stop_d = 1'b1;
                end else begin
                    tx_st_d = TX_IDLE;
                end
            end
            default: tx_st_d = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_st_q   <= TX_IDLE;
            tx_sr_q   <= 8'h0;
            tx_cnt_q  <= 3'h0;
            tx_sub_q  <= 4'h0;
            tx_stop_q <= 1'b0;
            tx_par_q  <= 1'b0;
        end else begin
            tx_st_q   <= tx_st_d;
            tx_sr_q   <= tx_sr_d;
            tx_cnt_q  <= tx_cnt_d;
            tx_sub_q  <= tx_sub_d;
            tx_stop_q <= tx_stop_d;
            if (tx_load) tx_par_q <= tx_par_new;
        end
    end

    // ------------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------------
    asp_rx_st_t  rx_st_q, rx_st_d;
    logic [7:0]  rx_sr_q, rx_sr_d;
    logic [2:0]  rx_cnt_q, rx_cnt_d;
    logic [3:0]  rx_sub_q, rx_sub_d;
    logic        rx_par_q, rx_par_d;
    logic        rx_push;
    asp_rxchar_t rx_char;
    // local loop feeds the receiver from our own transmitter
    wire rx_src = (ctrl_q.mode == MODE_LLOOP) ? tx_line : rxd_s;
    wire rx_act = ctrl_q.rx_en & (ctrl_q.mode != MODE_RLOOP);
    wire rx_smp = smp_tick & (rx_sub_q == SUB_MAX);
    // lsb-first shift lands at the top, so realign short characters
    wire [7:0] rx_data = rx_sr_q >> (2'h3 - ctrl_q.len);
    wire rx_brk = ~rx_src & (rx_sr_q == 8'h0) & ~rx_par_q;

    // assemble the received character at the stop sample
    always_comb begin
        rx_char.data = rx_data;
        rx_char.addr = ctrl_q.multidrop & rx_par_q;
        rx_char.perr = ctrl_q.par_en & ~ctrl_q.multidrop &
                       (rx_par_q != par_calc(rx_data, ctrl_q));
        rx_char.ferr = ~rx_src & ~rx_brk;
        rx_char.brk  = rx_brk;
    end

    // start check at mid-bit, then one sample every sixteen ticks
    always_comb begin
        rx_st_d  = rx_st_q;
        rx_sr_d  = rx_sr_q;
        rx_cnt_d = rx_cnt_q;
        rx_par_d = rx_par_q;
        rx_push  = 1'b0;
        rx_sub_d = smp_tick ? rx_sub_q + 4'h1 : rx_sub_q;
        case (rx_st_q)
            RX_IDLE: if (smp_tick && !rx_src && rx_act) begin
                rx_sub_d = 4'h0;
                rx_sr_d  = 8'h0;
                rx_par_d = 1'b0;
                rx_st_d  = RX_START;
            end
            RX_START: if (smp_tick && rx_sub_q == SUB_HALF) begin
                rx_sub_d = 4'h0;
                rx_cnt_d = 3'h0;
                rx_st_d  = rx_src ? RX_IDLE : RX_DATA;  // glitch reject
            end
            RX_DATA: if (rx_smp) begin
                rx_sr_d  = {rx_src, rx_sr_q[7:1]};
                rx_cnt_d = rx_cnt_q + 3'h1;
                if (rx_cnt_q == last_bit) begin
                    rx_st_d = par_on ? RX_PAR : RX_STOP;
                end
            end
            RX_PAR: if (rx_smp) begin
                rx_par_d = rx_src;
                rx_st_d  = RX_STOP;
            end
            RX_STOP: if (rx_smp) begin
                rx_push = 1'b1;
                rx_st_d = rx_brk ? RX_BRKW : RX_IDLE;
            end
            RX_BRKW: if (rx_src) begin   // one report per break
                rx_st_d = RX_IDLE;
            end
            default: rx_st_d = RX_IDLE;
        endcase
        if (!rx_act) rx_st_d = RX_IDLE;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_st_q  <= RX_IDLE;
            rx_sr_q  <= 8'h0;
            rx_cnt_q <= 3'h0;
            rx_sub_q <= 4'h0;
            rx_par_q <= 1'b0;
        end else begin
            rx_st_q  <= rx_st_d;
            rx_sr_q  <= rx_sr_d;
            rx_cnt_q <= rx_cnt_d;
            rx_sub_q <= rx_sub_d;
            rx_par_q <= rx_par_d;
        end
    end

    // three holding words behind the shifter
    asp_rx_fifo u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .push_i      (rx_push & ~rx_full),
        .push_data_i (rx_char),
        .pop_i       (rx_pop),
        .rd_data_o   (fifo_head),
        .count_o     (fifo_cnt)
    );

    // ------------------------------------------------------------------
    // events, status and read mux
    // ------------------------------------------------------------------
    logic [EV_W-1:0] ev;
    always_comb begin
        ev           = '0;
        ev[EV_RXRDY] = rx_push & ~rx_full;
        ev[EV_TXEMP] = tx_load;
        ev[EV_OVR]   = rx_push & rx_full;
        ev[EV_FRM]   = rx_push & rx_char.ferr;
        ev[EV_PAR]   = rx_push & rx_char.perr;
        ev[EV_BRK]   = rx_push & rx_char.brk;
    end
    // a new event beats a same-cycle clear
    wire [EV_W-1:0] ist_clr = (wr && idx == REG_ISR) ? clr_m[EV_W-1:0]
                                                       : '0;
    wire [EV_W-1:0] ist_d   = (ist_q & ~ist_clr) | ev;

    logic [3:0] stat;
    always_comb begin
        stat            = 4'h0;
        stat[ST_TXEMP]  = ~hold_v_q;
        stat[ST_TXDONE] = ~hold_v_q & (tx_st_q == TX_IDLE);
        stat[ST_RXRDY]  = ~rx_empty;
        stat[ST_RXFULL] = rx_full;
    end

    always_comb begin
        case (idx)
            REG_CTRL: rd_mux = {16'h0, ctrl_q};
            REG_DIV:  rd_mux = {16'h0, div_q};
            REG_RXD:  rd_mux = {20'h0, fifo_head};
            REG_STAT: rd_mux = {28'h0, stat};
            REG_ISR:  rd_mux = {26'h0, ist_q};
            REG_IMR:  rd_mux = {26'h0, imr_q};
            default:  rd_mux = 32'h0;   // txd and unmapped read zero
        endcase
    end

    // ------------------------------------------------------------------
    // register file and bus answer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q   <= asp_ctrl_t'(CTRL_RST);
            div_q    <= DIV_RST;
            imr_q    <= '0;
            ist_q    <= '0;
            hold_q   <= 9'h0;
            hold_v_q <= 1'b0;
            ack_o    <= 1'b0;
            dat_o    <= 32'h0;
        end else begin
            ack_o <= acc;       // one wait state, drops next cycle
            if (rd) dat_o <= rd_mux;
            if (wr && idx == REG_CTRL) ctrl_q <= asp_ctrl_t'(ctrl_m[15:0]);
            if (wr && idx == REG_DIV) div_q <= div_m[15:0];
            if (wr && idx == REG_IMR) imr_q <= imr_m[EV_W-1:0];
            ist_q <= ist_d;
            if (txd_wr) begin
                hold_q   <= txd_m[8:0];
                hold_v_q <= 1'b1;
            end else if (tx_load) begin
                hold_v_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // registered pins, interrupt and dma
    // ------------------------------------------------------------------
    // echo and remote loop copy the line back; break overrides all
    wire tx_pin_d = ctrl_q.brk ? 1'b0 :
                    (ctrl_q.mode == MODE_ECHO ||
                     ctrl_q.mode == MODE_RLOOP) ? rxd_s :
                    (ctrl_q.mode == MODE_LLOOP) ? 1'b1 : tx_line;
    // deassert one word early so a character in flight still fits
    wire rts_n_d = ctrl_q.flow_en & (fifo_cnt >= RTS_LIMIT);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_tx_o             <= 1'b1;
            request_to_send_out_n_o <= 1'b1;
            irq_o                   <= 1'b0;
            dma_rx_req_o            <= 1'b0;
            dma_tx_req_o            <= 1'b0;
        end else begin
            serial_tx_o             <= tx_pin_d;
            request_to_send_out_n_o <= rts_n_d;
            irq_o                   <= |(ist_d & imr_q);
            dma_rx_req_o <= ctrl_q.dma_rx_ne ? ~rx_empty
                                             : rx_full;
            dma_tx_req_o <= ctrl_q.tx_en & ~hold_v_q;
        end
    end
endmodule

// file: dv/asp_chk.sv
// checker: bus timing, readback and line rules of the serial port
// assumes it is bound to asp_top and sees only its ports
`timescale 1ns/1ps
module asp_chk
    import asp_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [31:0] dat_o,
    input  wire logic        ack_o,
    input  wire logic        serial_tx_o,
    input  wire logic        request_to_send_out_n_o,
    input  wire logic        dma_tx_req_o
);
    logic [15:0] ctrl_q;
    logic [15:0] div_q;
    wire         acc = cyc_i && stb_i && !ack_o;
    // shadows follow the accept edge; full byte lanes assumed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
            div_q  <= DIV_RST;
        end else if (acc && we_i && adr_i[4:2] == REG_CTRL) begin
            ctrl_q <= dat_i[15:0];
        end else if (acc && we_i && adr_i[4:2] == REG_DIV) begin
            div_q  <= dat_i[15:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence rd_s(logic [2:0] a);
        acc && !we_i && adr_i[4:2] == a;
    endsequence
    ack_lat_a: assert property (acc |=> ack_o)
        else $error("ack missing after request");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (ack_o |-> $past(acc))
        else $error("ack without request");
    ctrl_rd_a: assert property (
        rd_s(REG_CTRL) |=> dat_o == 32'(ctrl_q))
        else $error("control readback wrong");
    div_rd_a: assert property (rd_s(REG_DIV) |=> dat_o == 32'(div_q))
        else $error("divisor readback wrong");
    zero_rd_a: assert property (rd_s(REG_TXD) or rd_s(3'h7) |=> dat_o == '0)
        else $error("hole or tx data not zero");
    brk_line_a: assert property (
        (ctrl_q[7] && ctrl_q[10:9] == MODE_NORM) [*3] |-> !serial_tx_o)
        else $error("break not on line");
    rts_off_a: assert property (
        (!ctrl_q[8]) [*3] |-> !request_to_send_out_n_o)
        else $error("rts not asserted with flow off");
    dma_tx_a: assert property (
        dma_tx_req_o |-> ctrl_q[14] || $past(ctrl_q[14]))
        else $error("tx dma while tx disabled");
endmodule
bind asp_top asp_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .dat_i, .dat_o, .ack_o, .serial_tx_o, .request_to_send_out_n_o,
    .dma_tx_req_o);

// file: dv/asp_remote.sv
// remote serial partner: sends and captures frames, lsb first
// assumes 512 system clocks per bit (divisor 1)
`timescale 1ns/1ps
module asp_remote #(
    parameter int BIT = 512
) (
    input  wire logic clk_i,
    input  wire logic line_i,
    input  wire logic rts_n_i,
    output logic      line_o,
    output logic      cts_n_o
);
    initial begin
        line_o  = 1'b1;
        cts_n_o = 1'b0;
    end
    // start bit only once the port asks for data
    task automatic send(input logic [10:0] b, input int n);
        logic [12:0] f;
        f = (13'(b) << 1) | (13'h1 << (n + 1));
        while (rts_n_i) @(posedge clk_i);
        for (int i = 0; i <= n + 1; i++) begin
            line_o <= f[i];
            repeat (BIT) @(posedge clk_i);
        end
    endtask
    // mid-bit sampling; start bit itself is not returned
    task automatic recv(output logic [10:0] b, input int n);
        b = '0;
        while (line_i) @(posedge clk_i);
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            repeat (BIT) @(posedge clk_i);
            b[i] = line_i;
        end
    endtask
endmodule

// file: dv/testbench.sv
// testbench: register bus, character path and interrupt checks
// assumes asp_top, the remote partner and the bound checker
`timescale 1ns/1ps
module testbench
    import asp_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [4:0]  adr = '0;
    logic [31:0] dat = '0, rdat, q, rs = 32'h768f;
    logic        ack, tx, rx, cts_n, rts_n, irq, dmr, dmt, ext = 1'b0;
    int          n_mismatch = 0, compares = 0;
    always #20 clk = ~clk;
    // timer pin toggles each clock: a rising edge every second clock
    always @(posedge clk) ext <= ~ext;
    asp_top u_asp_top (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(rdat),
        .ack_o(ack), .serial_rx_i(rx), .serial_tx_o(tx),
        .clear_to_send_in_n_i(cts_n), .request_to_send_out_n_o(rts_n),
        .external_timer_clock_input_i(ext), .irq_o(irq),
        .dma_rx_req_o(dmr), .dma_tx_req_o(dmt));
    asp_remote u_asp_remote (.clk_i(clk), .line_i(tx), .rts_n_i(rts_n),
        .line_o(rx), .cts_n_o(cts_n));
    // one classic cycle; the slave sets the pace, the watchdog ends a hang
    task automatic wb(input logic w, input logic [4:0] a, logic [31:0] d);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do @(posedge clk);
        while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic chk(input string s, input logic [31:0] g, e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    // expected frame after the start bit: data, parity, stop bits
    function automatic logic [10:0] frm(logic [6:0] c, logic [7:0] d);
        int         n;
        logic [7:0] m;
        n = c[1:0] + 5;
        m = d & ~(8'hff << n);
        return 11'(m) | (11'(c[2] & (c[4] ? c[5] : ^m ^ c[3])) << n)
            | (11'(c[6] ? 3 : 1) << (n + c[2]));
    endfunction
    task automatic test_done();
        if (n_mismatch == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
    initial begin
        logic [31:0] c, d;
        logic [10:0] f;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wb(0, 5'h00, 0);
        chk("ctrl_rst", q, 32'h3);
        wb(0, 5'h04, 0);
        chk("div_rst", q, 32'h1);
        wb(0, 5'h1c, 0);
        chk("hole", q, 0);
        // every length, random parity, forced level and stop count
        for (int i = 0; i < 4; i++) begin
            c = (rnd() & 32'h7c) | i | 32'hc000;
            d = rnd();
            wb(1, 5'h00, c);
            chk("dma_tx", dmt, 1);
            wb(1, 5'h08, d & 32'hff);
            u_asp_remote.recv(f, i + 6 + c[2] + c[6]);
            chk("tx_frame", f, frm(c[6:0], d[7:0]));
        end
        wb(1, 5'h00, 32'hc080);
        repeat (4) @(posedge clk);
        chk("brk_line", tx, 0);
        wb(1, 5'h00, 32'he107);
        wb(1, 5'h18, 1);
        // good then bad parity, held unread so flow control deasserts rts_n
        d = rnd();
        u_asp_remote.send({2'b0, ^d[7:0], d[7:0]}, 9);
        u_asp_remote.send({2'b0, ~^d[15:8], d[15:8]}, 9);
        repeat (20) @(posedge clk);
        chk("rts_n", rts_n, 1);
        chk("irq", irq, 1);
        wb(0, 5'h10, 0);
        chk("status", q[3:0], 4'h7);
        chk("dma_rx", dmr, 1);
        wb(0, 5'h0c, 0);
        chk("rx_1", q[11:0], {4'h0, d[7:0]});
        wb(0, 5'h0c, 0);
        chk("rx_2", q[11:0], {4'h2, d[15:8]});
        wb(1, 5'h18, 0);
        chk("irq_mask", irq, 0);
        wb(1, 5'h14, 32'h3f);
        wb(1, 5'h18, 32'h3f);
        chk("irq_clr", irq, 0);
        u_asp_remote.send(11'h0, 10);
        repeat (20) @(posedge clk);
        wb(0, 5'h0c, 0);
        chk("rx_brk", q[11], 1);
        // timer clock, divisor 16, address character over the local loop
        wb(1, 5'h04, 32'h10);
        wb(1, 5'h00, 32'hdc03);
        d = rnd();
        wb(1, 5'h08, {23'h0, 1'b1, d[7:0]});
        repeat (300) @(posedge clk);
        chk("lloop_pin", tx, 1);
        repeat (5700) @(posedge clk);
        wb(0, 5'h0c, 0);
        chk("rx_md", q[11:0], {4'h1, d[7:0]});
        test_done();
    end
endmodule
